// File: inc/hps_pkg.sv
// package for the hot-plug slot power sequencer: constants, states and carriers
package hps_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_PS  = 25000;    // 40 MHz core clock
  localparam int unsigned POR_TIME_US    = 500;      // standby valid time before reset ends
  localparam int unsigned POR_CYCLES     = (POR_TIME_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned POR_CNT_W      = 16;

  // ----------------------------------------------------------------
  // status field positions
  // ----------------------------------------------------------------
  localparam int unsigned SLOTS          = 2;
  localparam int unsigned SUPPLIES       = 4;        // 12V, -12V, 5V, 3.3V
  localparam int unsigned CS_OT_BIT      = 1;        // global overtemperature flag
  localparam int unsigned CS_MASK_BIT    = 3;        // interrupt_mask_bit
  localparam int unsigned CS_GPI_LO_BIT  = 4;        // general_input_pin a/b at bits 4 and 5
  localparam logic [7:0]  CS_RESET       = 8'h08;    // mask set after reset
  localparam logic [7:0]  STAT_RESET     = 8'h00;

  // ----------------------------------------------------------------
  // slot state machine, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    SLOT_OFF     = 4'h1,
    SLOT_ON      = 4'h2,
    SLOT_TRIPPED = 4'h4,
    SLOT_SPARE   = 4'h8
  } hps_slot_state_type;

  // per-slot hardware_control_path inputs
  typedef struct packed {
    logic main_en;
    logic auxiliary_power_enable;
  } hps_hw_ctl_type;

  // per-slot analog sense inputs from the protection unit
  typedef struct packed {
    logic [SUPPLIES-1:0] uv_ok;       // supply above undervoltage_lockout
    logic                main_oc_trip; // main overcurrent beyond fault timer
  } hps_sense_type;

  // per-slot outputs to the power stage
  typedef struct packed {
    logic main_on;
    logic five_volt_gate_drive;
    logic three_volt_gate_drive;
    logic auxiliary_output;
  } hps_slot_out_type;

endpackage

// File: logic/hps_por_timer.sv
// power-on reset timer: counts standby-valid time and holds the block in reset
`timescale 1ns/1ps
module hps_por_timer #(
  parameter int unsigned CYCLES = hps_pkg::POR_CYCLES
) (
  input  wire logic core_clk_i,
  input  wire logic sys_rst_i,
  input  wire logic standby_ok_i,
  output logic      por_active_o,
  output logic      por_done_pulse_o
);
  import hps_pkg::*;

  initial begin
    if (CYCLES < 1 || CYCLES >= (1 << POR_CNT_W)) $error("por cycles out of range");
  end

  logic [POR_CNT_W-1:0] cnt_q, cnt_d;
  logic                 act_q, act_d;

  // any drop of standby restarts the full interval
  always_comb begin
    cnt_d = cnt_q;
    act_d = act_q;
    if (!standby_ok_i) begin
      cnt_d = '0;
      act_d = 1'b1;
    end else if (act_q) begin
      if (cnt_q == POR_CNT_W'(CYCLES - 1)) begin
        act_d = 1'b0;
      end else begin
        cnt_d = cnt_q + POR_CNT_W'(1);
      end
    end
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cnt_q <= '0;
      act_q <= 1'b1;
    end else begin
      cnt_q <= cnt_d;
      act_q <= act_d;
    end
  end

  assign por_active_o     = act_q;
  assign por_done_pulse_o = act_q && !act_d;

  // helper: time standby has been continuously valid
  logic [POR_CNT_W:0] valid_run_q;
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      valid_run_q <= '0;
    end else if (!standby_ok_i) begin
      valid_run_q <= '0;
    end else if (valid_run_q != '1) begin
      valid_run_q <= valid_run_q + (POR_CNT_W+1)'(1);
    end
  end

  a_por_min_time: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    $fell(por_active_o) |-> valid_run_q >= (POR_CNT_W+1)'(CYCLES))
    else $error("reset ended before standby valid long enough");
  a_por_restart: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    !standby_ok_i |=> por_active_o && cnt_q == '0)
    else $error("standby drop did not restart reset");
  c_por_done: cover property (@(posedge core_clk_i) disable iff (sys_rst_i) $fell(por_active_o));
endmodule

// File: logic/hps_slot_ctl.sv
// one slot: enable edge detection, breaker trip and gate-drive outputs
`timescale 1ns/1ps
module hps_slot_ctl (
  input  wire logic                      core_clk_i,
  input  wire logic                      sys_rst_i,
  input  wire logic                      por_active_i,
  input  wire logic                      main_req_i,
  input  wire logic                      aux_req_i,
  input  wire hps_pkg::hps_sense_type    sense_i,
  output hps_pkg::hps_slot_out_type      out_o,
  output logic                           trip_pulse_o
);
  import hps_pkg::*;

  hps_slot_state_type st_q, st_d;
  logic               req_q, req_d;
  logic               all_ok;

  assign all_ok = &sense_i.uv_ok;

  // only a rising request with all supplies valid turns the slot on
  always_comb begin
    st_d         = st_q;
    req_d        = main_req_i;
    trip_pulse_o = 1'b0;
    if (por_active_i) begin
      st_d  = SLOT_OFF;
      // pin history keeps tracking here: a level held through reset is no edge
    end else begin
      case (st_q)
        SLOT_OFF: begin
          if (main_req_i && !req_q && all_ok) st_d = SLOT_ON;
        end
        SLOT_ON: begin
          if (sense_i.main_oc_trip || !all_ok) begin
            st_d         = SLOT_TRIPPED;
            trip_pulse_o = 1'b1;
          end else if (!main_req_i) begin
            st_d = SLOT_OFF;
          end
        end
        SLOT_TRIPPED: begin
          if (!main_req_i) st_d = SLOT_OFF;               // fresh edge needed
        end
        default: st_d = SLOT_OFF;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_q  <= SLOT_OFF;
      req_q <= 1'b0;
    end else begin
      st_q  <= st_d;
      req_q <= req_d;
    end
  end

  // registered outputs; gates low whenever off; aux independent of main trips
  hps_slot_out_type out_q, out_d;
  always_comb begin
    out_d.main_on               = (st_d == SLOT_ON);
    out_d.five_volt_gate_drive  = (st_d == SLOT_ON);
    out_d.three_volt_gate_drive = (st_d == SLOT_ON);
    out_d.auxiliary_output      = aux_req_i && !por_active_i;
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      out_q <= '0;
    end else begin
      out_q <= out_d;
    end
  end
  assign out_o = out_q;

  a_gate_low_off: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    st_q != SLOT_ON |-> !out_q.five_volt_gate_drive && !out_q.three_volt_gate_drive)
    else $error("gate driven while slot off");
  a_trip_cuts: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (st_q == SLOT_ON && sense_i.main_oc_trip && !por_active_i) |=> !out_q.main_on ##1 !out_q.main_on)
    else $error("main stayed on after trip");
  a_on_edge: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (st_q == SLOT_OFF && !req_q && main_req_i && all_ok && !por_active_i) |=> out_q.main_on)
    else $error("rising enable did not start slot");
  a_no_reon: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (st_q == SLOT_TRIPPED && main_req_i) |=> !out_q.main_on)
    else $error("tripped slot came back without new edge");
  c_trip: cover property (@(posedge core_clk_i) disable iff (sys_rst_i) trip_pulse_o);
endmodule

// File: logic/hps_sequencer.sv
// two-slot hot-plug power sequencer: reset timing, path select, status and interrupt
//
// Function
// - reset ends after 500us of valid standby
// - internal state cleared at reset end, except enable edge history and live input bits
// - standby drop restarts the reset interval
// - serial requests refused during reset interval
// - all slot outputs off during reset
// - rising main enable with supplies valid starts slot
// - gate drives low while slot off
// - power from serial port or pins
// - pin path enables/faults; interrupt in either path
// - serial reports supply faults and inputs
// - main overcurrent trip cuts mains, aux kept
// - new enable edge re-enables after trip
// - writing one to fault bit clears it
// - interrupt only after reset, mask cleared
`timescale 1ns/1ps
module hps_sequencer #(
  parameter int unsigned POR_CYCLES_P = hps_pkg::POR_CYCLES
) (
  input  wire logic                                  core_clk_i,
  input  wire logic                                  sys_rst_i,
  input  wire logic                                  standby_ok_i,
  // hardware_control_path
  input  wire hps_pkg::hps_hw_ctl_type [1:0]         hw_ctl_i,
  output logic [1:0]                                 fault_n_o,
  // power stage and protection
  input  wire hps_pkg::hps_sense_type [1:0]          sense_i,
  output hps_pkg::hps_slot_out_type [1:0]            slot_o,
  input  wire logic                                  over_temp_i,
  input  wire logic [1:0]                            general_input_pin_i,
  // management_serial_path, already decoded into byte accesses
  input  wire logic                                  serial_mode_i,
  input  wire logic                                  mgmt_wr_i,
  input  wire logic [1:0]                            mgmt_sel_i,
  input  wire logic [7:0]                            mgmt_wdata_i,
  output logic                                       mgmt_ready_o,
  output logic [7:0]                                 mgmt_rdata_o,
  output logic                                       int_n_o
);
  import hps_pkg::*;

  // ------------------------------------------------------------------
  // parameter check
  // ------------------------------------------------------------------
  initial begin
    if (POR_CYCLES_P < 1) $error("por cycle count must be at least one");
  end

  // ------------------------------------------------------------------
  // power-on reset timer
  // ------------------------------------------------------------------
  logic por_active;
  logic por_done;

  hps_por_timer #(
    .CYCLES (POR_CYCLES_P)
  ) u_por (
    .core_clk_i       (core_clk_i),
    .sys_rst_i        (sys_rst_i),
    .standby_ok_i     (standby_ok_i),
    .por_active_o     (por_active),
    .por_done_pulse_o (por_done)
  );

  // serial port ready only after the interval
  assign mgmt_ready_o = !por_active;

  // ------------------------------------------------------------------
  // serial control registers: selector 0/1 slot control, 2 common status
  // ------------------------------------------------------------------
  logic [1:0] ser_main_q, ser_main_d;
  logic [1:0] ser_aux_q,  ser_aux_d;
  logic       wr_ok;

  // accesses only after reset; power writes only in serial mode
  assign wr_ok = mgmt_wr_i && !por_active;

  always_comb begin
    ser_main_d = ser_main_q;
    ser_aux_d  = ser_aux_q;
    if (por_active) begin
      ser_main_d = '0;
      ser_aux_d  = '0;
    end else if (wr_ok && serial_mode_i && mgmt_sel_i < 2'(SLOTS)) begin
      // pin mode ignores power writes so the two paths never fight
      ser_main_d[mgmt_sel_i[0]] = mgmt_wdata_i[0];
      ser_aux_d[mgmt_sel_i[0]]  = mgmt_wdata_i[1];
    end
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ser_main_q <= '0;
      ser_aux_q  <= '0;
    end else begin
      ser_main_q <= ser_main_d;
      ser_aux_q  <= ser_aux_d;
    end
  end

  // ------------------------------------------------------------------
  // slots
  // ------------------------------------------------------------------
  logic [1:0] main_req;
  logic [1:0] aux_req;
  logic [1:0] trip;

  genvar g;
  generate
    for (g = 0; g < SLOTS; g++) begin : g_slot
      // path select: pins are ignored in serial mode
      assign main_req[g] = serial_mode_i ? ser_main_q[g] : hw_ctl_i[g].main_en;
      assign aux_req[g]  = serial_mode_i ? ser_aux_q[g]
                                         : hw_ctl_i[g].auxiliary_power_enable;
      hps_slot_ctl u_slot (
        .core_clk_i   (core_clk_i),
        .sys_rst_i    (sys_rst_i),
        .por_active_i (por_active),
        .main_req_i   (main_req[g]),
        .aux_req_i    (aux_req[g]),
        .sense_i      (sense_i[g]),
        .out_o        (slot_o[g]),
        .trip_pulse_o (trip[g])
      );
    end
  endgenerate

  // ------------------------------------------------------------------
  // fault status: bits 3:0 supply undervoltage, bit 4 breaker
  // ------------------------------------------------------------------
  logic [1:0][7:0] stat_q, stat_d;
  logic [7:0]      cs_q, cs_d;

  // returns set bits for one slot's events
  function automatic logic [7:0] slot_events(input hps_sense_type s, input logic t, input logic en);
    logic [7:0] e;
    e = '0;
    if (en) begin
      e[SUPPLIES-1:0] = ~s.uv_ok;
      e[SUPPLIES]     = t;
    end
    return e;
  endfunction

  always_comb begin
    stat_d = stat_q;
    cs_d   = cs_q;
    if (por_active) begin
      stat_d = {STAT_RESET, STAT_RESET};
      cs_d   = CS_RESET;
    end else begin
      // write-one-to-clear first, then set wins over the clear
      if (wr_ok && mgmt_sel_i < 2'(SLOTS)) begin
        stat_d[mgmt_sel_i[0]] = stat_q[mgmt_sel_i[0]] & ~mgmt_wdata_i;
      end
      if (wr_ok && mgmt_sel_i == 2'(SLOTS)) begin
        cs_d[CS_OT_BIT]   = cs_q[CS_OT_BIT] & ~mgmt_wdata_i[CS_OT_BIT];
        cs_d[CS_MASK_BIT] = mgmt_wdata_i[CS_MASK_BIT];
      end
      for (int i = 0; i < SLOTS; i++) begin
        stat_d[i] = stat_d[i] | slot_events(sense_i[i], trip[i], main_req[i]);
      end
      if (over_temp_i) cs_d[CS_OT_BIT] = 1'b1;
    end
    // inputs are live, not latched
    cs_d[CS_GPI_LO_BIT +: 2] = general_input_pin_i;
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      stat_q <= {STAT_RESET, STAT_RESET};
      cs_q   <= CS_RESET;
    end else begin
      stat_q <= stat_d;
      cs_q   <= cs_d;
    end
  end

  // ------------------------------------------------------------------
  // read data and interrupt
  // ------------------------------------------------------------------
  logic [7:0] rdata_q, rdata_d;
  logic       int_n_q, int_n_d;
  logic [1:0] fault_n_q, fault_n_d;
  logic       any_fault;

  assign any_fault = (|stat_q[0]) || (|stat_q[1]) || cs_q[CS_OT_BIT];

  always_comb begin
    case (mgmt_sel_i)
      2'h0:    rdata_d = stat_q[0];
      2'h1:    rdata_d = stat_q[1];
      2'h2:    rdata_d = cs_q;
      default: rdata_d = 8'h00;
    endcase
    if (por_active) rdata_d = 8'h00;
    // mask set by reset keeps interrupt idle until software clears it
    int_n_d = !(any_fault && !cs_q[CS_MASK_BIT] && !por_active);
    for (int i = 0; i < SLOTS; i++) begin
      // pin fault only reported in pin mode
      fault_n_d[i] = !(!serial_mode_i && |stat_q[i] && !por_active);
    end
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rdata_q   <= 8'h00;
      int_n_q   <= 1'b1;
      fault_n_q <= 2'h3;
    end else begin
      rdata_q   <= rdata_d;
      int_n_q   <= int_n_d;
      fault_n_q <= fault_n_d;
    end
  end

  assign mgmt_rdata_o = rdata_q;
  assign int_n_o      = int_n_q;
  assign fault_n_o    = fault_n_q;

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  a_por_outputs_off: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    por_active |=> !slot_o[0].main_on && !slot_o[1].main_on && !slot_o[0].auxiliary_output
                   && !slot_o[1].auxiliary_output)
    else $error("slot output on during reset interval");
  a_por_clears: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    por_done |=> stat_q[0] == STAT_RESET && stat_q[1] == STAT_RESET && cs_q[CS_MASK_BIT])
    else $error("state not cleared after reset");
  a_serial_refused: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    por_active |-> !mgmt_ready_o && !wr_ok)
    else $error("serial access accepted during reset");
  a_int_masked: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    cs_q[CS_MASK_BIT] |=> int_n_o)
    else $error("interrupt asserted while masked");
  a_fault_clear: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (wr_ok && mgmt_sel_i == 2'h0 && mgmt_wdata_i == 8'hFF && !trip[0]
     && &sense_i[0].uv_ok) |=> stat_q[0] == 8'h00)
    else $error("echo write did not clear slot fault");
  a_pin_ignored: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (!serial_mode_i && wr_ok) |=> $stable(ser_main_q))
    else $error("serial power write took effect in pin mode");
  a_fault_pin_idle: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    serial_mode_i |=> fault_n_o == 2'h3)
    else $error("fault pin driven in serial mode");
  a_int_on_fault: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (any_fault && !cs_q[CS_MASK_BIT] && !por_active) |=> !int_n_o)
    else $error("unmasked fault did not raise interrupt");
  a_ot_flag: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (over_temp_i && !por_active) |=> cs_q[CS_OT_BIT])
    else $error("overtemperature not reported");
  a_ot_clear: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (wr_ok && mgmt_sel_i == 2'h2 && mgmt_wdata_i[CS_OT_BIT] && !over_temp_i) |=> !cs_q[CS_OT_BIT])
    else $error("overtemperature flag not cleared");
  a_gpi_live: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    !por_active |=> cs_q[CS_GPI_LO_BIT +: 2] == $past(general_input_pin_i))
    else $error("general input status stale");
  a_unmapped_zero: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (!por_active && mgmt_sel_i == 2'h3) |=> mgmt_rdata_o == 8'h00)
    else $error("unmapped selector read not zero");
  a_por_rdata_zero: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    por_active |=> mgmt_rdata_o == 8'h00)
    else $error("read data shown during reset");

  // ------------------------------------------------------------------
  // per-slot checks
  // ------------------------------------------------------------------
  // the same status and output rules hold for either slot
  generate
    for (g = 0; g < SLOTS; g++) begin : g_chk
      a_fault_pin_low: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        (!serial_mode_i && (|stat_q[g]) && !por_active) |=> !fault_n_o[g])
        else $error("slot fault pin not driven");
      a_uv_reported: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        (!por_active && main_req[g] && !(&sense_i[g].uv_ok)) |=> (|stat_q[g][SUPPLIES-1:0]))
        else $error("supply fault not reported");
      a_trip_reported: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        (trip[g] && main_req[g]) |=> stat_q[g][SUPPLIES])
        else $error("breaker trip not reported");
      a_aux_kept: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        (!por_active && aux_req[g]) |=> slot_o[g].auxiliary_output)
        else $error("auxiliary output dropped");
      a_off_no_req: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        !main_req[g] |=> !slot_o[g].main_on)
        else $error("main on without request");
    end
  endgenerate

  c_int_fires: cover property (@(posedge core_clk_i) disable iff (sys_rst_i) $fell(int_n_o));
  c_serial_on: cover property (@(posedge core_clk_i) disable iff (sys_rst_i)
    serial_mode_i && $rose(slot_o[0].main_on));
  c_pin_on: cover property (@(posedge core_clk_i) disable iff (sys_rst_i)
    !serial_mode_i && $rose(slot_o[1].main_on));
endmodule

// File: dv/hps_host_model.sv
// host model: drives the hardware enables and the decoded management byte port
`timescale 1ns/1ps
module hps_host_model (
  input  wire logic                     core_clk_i,
  input  wire logic                     mgmt_ready_i,
  output hps_pkg::hps_hw_ctl_type [1:0] hw_ctl_o,
  output logic                          serial_mode_o,
  output logic                          mgmt_wr_o,
  output logic [1:0]                    mgmt_sel_o,
  output logic [7:0]                    mgmt_wdata_o
);
  import hps_pkg::*;

  // ----------------------------------------------------------------
  // idle levels, pin path selected
  // ----------------------------------------------------------------
  initial begin
    hw_ctl_o      = '0;
    serial_mode_o = 1'b0;
    mgmt_wr_o     = 1'b0;
    mgmt_sel_o    = 2'h3;
    mgmt_wdata_o  = 8'h00;
  end

  // serial control grounds the pins so a lost link cannot power a slot
  task automatic set_mode(input logic ser);
    @(negedge core_clk_i);
    serial_mode_o = ser;
    if (ser) begin
      hw_ctl_o = '0;
    end
  endtask

  // pin levels are only moved while the pin path owns power control
  task automatic pin(input int s, input logic m, input logic a);
    @(negedge core_clk_i);
    if (!serial_mode_o) begin
      hw_ctl_o[s].main_en                = m;
      hw_ctl_o[s].auxiliary_power_enable = a;
    end
  endtask

  task automatic select(input logic [1:0] sel);
    @(negedge core_clk_i);
    mgmt_sel_o = sel;
  endtask

  // waits until ready is seen high at a falling edge, or at most 200 more falling edges, then drives one write strobe for one cycle
  task automatic ser_write(input logic [1:0] sel, input logic [7:0] d);
    int n;
    n = 0;
    @(negedge core_clk_i);
    while (!mgmt_ready_i && n < 200) begin
      @(negedge core_clk_i);
      n++;
    end
    mgmt_sel_o   = sel;
    mgmt_wdata_o = (!serial_mode_o && sel != 2'h2) ? {d[7:2], 2'b00} : d;
    mgmt_wr_o    = 1'b1;
    @(negedge core_clk_i);
    mgmt_wr_o    = 1'b0;
    mgmt_wdata_o = ~mgmt_wdata_o;
  endtask
endmodule

// File: dv/test_hps_sequencer.sv
// self-checking bench for the two-slot hot-plug power sequencer
`timescale 1ns/1ps
module test_hps_sequencer;
  import hps_pkg::*;

  localparam int unsigned POR_N = 20;  // shortened reset interval
  logic                          core_clk_i = 1'b0;
  logic                          sys_rst_i  = 1'b1;
  logic                          standby_ok_i = 1'b1;
  hps_hw_ctl_type [1:0]          hw_ctl;
  logic [1:0]                    fault_n;
  hps_sense_type [1:0]           sense = '0;
  hps_slot_out_type [1:0]        slot;
  logic                          over_temp = 1'b0;
  logic [1:0]                    gpi = 2'b10;
  logic                          ser_mode, wr, ready, int_n;
  logic [1:0]                    sel;
  logic [7:0]                    wdata, rdata;
  int                            n_mismatch = 0;
  int                            checks_done = 0;
  int                            cycles = 0;

  always #12.5 core_clk_i = ~core_clk_i;

  hps_host_model u_host (.core_clk_i(core_clk_i), .mgmt_ready_i(ready), .hw_ctl_o(hw_ctl),
    .serial_mode_o(ser_mode), .mgmt_wr_o(wr), .mgmt_sel_o(sel), .mgmt_wdata_o(wdata));

  hps_sequencer #(.POR_CYCLES_P(POR_N)) uut (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
    .standby_ok_i(standby_ok_i), .hw_ctl_i(hw_ctl), .fault_n_o(fault_n), .sense_i(sense),
    .slot_o(slot), .over_temp_i(over_temp), .general_input_pin_i(gpi), .serial_mode_i(ser_mode),
    .mgmt_wr_i(wr), .mgmt_sel_i(sel), .mgmt_wdata_i(wdata), .mgmt_ready_o(ready),
    .mgmt_rdata_o(rdata), .int_n_o(int_n));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask

  // read data trails the selector by one registered cycle
  task automatic rd(input logic [1:0] s, input logic [7:0] exp);
    u_host.select(s);
    cyc(2);
    chk("rdata", rdata, exp);
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  // enable held high through reset must not start the slot
  task automatic t_por();
    sense[0].uv_ok = 4'hF;
    u_host.pin(0, 1'b1, 1'b0);
    sys_rst_i = 1'b0;
    cyc(POR_N - 4);
    chk("ready in por", {7'h00, ready}, 8'h00);
    chk("slot in por", {4'h0, slot[0]}, 8'h00);
    cyc(6);
    chk("ready after por", {7'h00, ready}, 8'h01);
    chk("held enable", {4'h0, slot[0]}, 8'h00);
    rd(2'h2, 8'h28);
    rd(2'h0, 8'h00);
    rd(2'h3, 8'h00);
  endtask

  // a standby dropout restarts the whole interval
  task automatic t_restart();
    @(negedge core_clk_i) standby_ok_i = 1'b0;
    @(negedge core_clk_i) standby_ok_i = 1'b1;
    chk("ready dropout", {7'h00, ready}, 8'h00);
    cyc(POR_N - 4);
    chk("ready restart", {7'h00, ready}, 8'h00);
    cyc(6);
    chk("ready again", {7'h00, ready}, 8'h01);
  endtask

  // pin path: rising edge with good supplies, refused with one supply low
  task automatic t_pin_on();
    u_host.pin(0, 1'b0, 1'b0);
    chk("off gates", {4'h0, slot[0]}, 8'h00);
    sense[1].uv_ok = 4'h7;
    u_host.pin(1, 1'b1, 1'b0);
    u_host.pin(0, 1'b1, 1'b1);
    cyc(3);
    chk("slot a on", {4'h0, slot[0]}, 8'h0F);
    chk("slot b uv", {4'h0, slot[1]}, 8'h00);
    u_host.pin(1, 1'b0, 1'b0);
    sense[1].uv_ok = 4'hF;
    chk("uv fault_n", {6'h00, fault_n}, 8'h01);
    rd(2'h1, 8'h08);
    u_host.ser_write(2'h1, 8'h08);
    rd(2'h1, 8'h00);
    u_host.pin(1, 1'b1, 1'b0);
    cyc(2);
    chk("slot b on", {4'h0, slot[1]}, 8'h0E);
    u_host.pin(1, 1'b0, 1'b0);
  endtask

  // trip drops mains only; interrupt gated by mask, cleared by writing one
  task automatic t_trip_int();
    @(negedge core_clk_i) sense[0].main_oc_trip = 1'b1;
    @(negedge core_clk_i) sense[0].main_oc_trip = 1'b0;
    cyc(3);
    chk("tripped", {4'h0, slot[0]}, 8'h01);
    chk("fault_n", {6'h00, fault_n}, 8'h02);
    chk("int masked", {7'h00, int_n}, 8'h01);
    rd(2'h0, 8'h10);
    u_host.ser_write(2'h2, 8'h02);
    cyc(2);
    chk("int on", {7'h00, int_n}, 8'h00);
    u_host.ser_write(2'h0, 8'h10);
    cyc(2);
    chk("int off", {7'h00, int_n}, 8'h01);
    rd(2'h0, 8'h00);
    u_host.pin(0, 1'b0, 1'b1);
    u_host.pin(0, 1'b1, 1'b1);
    cyc(3);
    chk("re-enable", {4'h0, slot[0]}, 8'h0F);
    u_host.pin(0, 1'b0, 1'b0);
    cyc(3);
  endtask

  // serial path owns power; pins grounded by the host
  task automatic t_serial();
    u_host.set_mode(1'b1);
    u_host.ser_write(2'h1, 8'h03);
    cyc(2);
    chk("ser slot b", {4'h0, slot[1]}, 8'h0F);
    chk("ser fault_n", {6'h00, fault_n}, 8'h03);
    u_host.ser_write(2'h0, 8'hFF);
    cyc(2);
    chk("ser slot a", {4'h0, slot[0]}, 8'h0F);
    rd(2'h0, 8'h00);
    u_host.ser_write(2'h0, 8'h00);
    u_host.ser_write(2'h3, 8'hFF);
    rd(2'h3, 8'h00);
    u_host.ser_write(2'h1, 8'h00);
    cyc(2);
    chk("ser off", {4'h0, slot[1]}, 8'h00);
  endtask

  // ----------------------------------------------------------------
  // main sequence and hang guard
  // ----------------------------------------------------------------
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      summarize();
    end
  end

  initial begin
    cyc(4);
    t_por();
    t_restart();
    t_pin_on();
    t_trip_int();
    t_serial();
    summarize();
  end
endmodule
